// ==== include/utf_defines.vh ====
// register offsets, field positions and reset values of the transmit fifo
`ifndef UTF_DEFINES_VH
`define UTF_DEFINES_VH

`define UTF_OFF_EP_INDEX   8'hf0
`define UTF_OFF_DATA_PORT  8'hf3
`define UTF_OFF_CONTROL    8'hf4
`define UTF_OFF_FLAGS      8'hf5
`define UTF_OFF_BYTE_COUNT 8'hf6
`define UTF_OFF_STATUS     8'hf7

`define UTF_CTL_REWIND     0
`define UTF_CTL_ADVANCE    1
`define UTF_CTL_AUTO       2
`define UTF_CTL_ISO        3
`define UTF_CTL_CLEAR      7

`define UTF_FLG_OVF        0
`define UTF_FLG_URF        1
`define UTF_FLG_FULL       2
`define UTF_FLG_EMPTY      3
`define UTF_FLG_ARMED_LO   6

`define UTF_STAT_ACK       0
`define UTF_STAT_ERR       1

`define UTF_CTL_RESET      8'h04
`define UTF_FLG_RESET      8'h08
`define UTF_CNT_W          5

`endif

// ==== verilog/utf_byte_ram.v ====
// byte storage of one endpoint transmit fifo, registered read
`timescale 1ns/100ps
module utf_byte_ram #(
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire          ref_clk_i,
  input  wire          wr_en_i,
  input  wire [AW-1:0] wr_addr_i,
  input  wire [7:0]    wr_data_i,
  input  wire          rd_en_i,
  input  wire [AW-1:0] rd_addr_i,
  output reg  [7:0]    rd_data_o
);
  reg [7:0] mem_r [0:DEPTH-1];

  initial begin
    rd_data_o = 8'h00;
  end

  always @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
    if (rd_en_i) begin
      rd_data_o <= mem_r[rd_addr_i];
    end
  end
endmodule // utf_byte_ram

// ==== verilog/utf_count_ring.v ====
// two-entry byte count store, one entry per data set
`timescale 1ns/100ps
module utf_count_ring #(
  parameter CW = 5
) (
  input  wire          ref_clk_i,
  input  wire          rstn_i,
  input  wire          wr_en_i,
  input  wire          wr_set_i,
  input  wire [CW-1:0] wr_count_i,
  input  wire          rd_set_i,
  output wire [CW-1:0] rd_count_o
);
  reg [CW-1:0] cnt_r [0:1];

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r[0] <= {CW{1'b0}};
      cnt_r[1] <= {CW{1'b0}};
    end else if (wr_en_i) begin
      cnt_r[wr_set_i] <= wr_count_i;
    end
  end

  assign rd_count_o = cnt_r[rd_set_i];
endmodule // utf_count_ring

// ==== verilog/utf_tx_fifo.v ====
// endpoint-indexed usb transmit fifos with data set management
//
// Function
// - firmware data write stores byte at write pointer, pointer advances
// - engine fetch reads byte at read pointer, pointer advances
// - read marker holds set start; advance moves it to read pointer
// - rewind moves read pointer back to marker for retransmission
// - five-bit count store keeps one count per data set
// - two armed bits show loaded sets, reset to empty 00
// - armed bits choose next set; at 11 writes are discarded
// - count write: 00->01, 01/10->11, at 11 sets overrun
// - marker advance clears older armed bit; rewind leaves bits alone
// - auto management off: transfer end only updates ack and error bits
// - auto, non-iso ack: advance marker, clear that armed bit
// - auto, non-iso error: rewind pointer, armed bits unchanged
// - auto iso: advance marker on ack or error, clear armed bit at frame start
// - iso: firmware changes immediate, usb armed, underrun and status updates wait for frame start
// - advance bit moves marker, self-clears; needs rewind/auto/clear zero
// - rewind bit moves pointer, self-clears; needs advance/auto/clear zero
// - byte count zero arms an empty set
// - all registers other than the index act on the endpoint the index names
// - fetch from empty or past count sets sticky underrun, locks pointer
// - write to full fifo sets sticky overrun, pointer holds
// - ack and error update together and never both set
`timescale 1ns/100ps
`include "utf_defines.vh"
module utf_tx_fifo #(
  parameter NEP   = 2,
  parameter EPW   = 1,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire                  ref_clk_i,
  input  wire                  rstn_i,
  input  wire [7:0]            reg_addr_i,
  input  wire [7:0]            reg_wdata_i,
  input  wire                  reg_wr_i,
  input  wire                  reg_rd_i,
  output reg  [7:0]            reg_rdata_o,
  input  wire [EPW-1:0]        se_ep_i,
  input  wire                  se_fetch_i,
  output wire [7:0]            se_data_o,
  output reg  [`UTF_CNT_W-1:0] se_count_o,
  output wire                  se_ready_o,
  input  wire                  se_done_i,
  input  wire                  se_ack_i,
  input  wire                  se_err_i,
  input  wire                  sof_i
);
  localparam [AW:0] FULL_LEVEL = DEPTH;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  function [1:0] armed_dec;
    input [1:0] f;
    input       older;
    begin
      if (f == 2'b11) begin
        armed_dec = older ? 2'b01 : 2'b10;
      end else begin
        armed_dec = 2'b00;
      end
    end
  endfunction

  function rd_set_of;
    input [1:0] f;
    input       older;
    begin
      rd_set_of = (f == 2'b10) | ((f == 2'b11) & older);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // shared register state
  reg  [EPW-1:0]          ep_idx_r;
  reg  [EPW-1:0]          se_ep_q_r;
  wire [NEP*8-1:0]        ctl_all;
  wire [NEP*8-1:0]        flg_all;
  wire [NEP*8-1:0]        stat_all;
  wire [NEP*8-1:0]        dq_all;
  wire [NEP*`UTF_CNT_W-1:0] cnt_all;
  wire [NEP-1:0]          rdy_all;

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ep_idx_r    <= {EPW{1'b0}};
      se_ep_q_r   <= {EPW{1'b0}};
      reg_rdata_o <= 8'h00;
      se_count_o  <= {`UTF_CNT_W{1'b0}};
    end else begin
      se_ep_q_r  <= se_ep_i;
      se_count_o <= cnt_all[se_ep_i*`UTF_CNT_W +: `UTF_CNT_W];
      if (reg_wr_i && reg_addr_i == `UTF_OFF_EP_INDEX) begin
        ep_idx_r <= reg_wdata_i[EPW-1:0];
      end
      reg_rdata_o <= 8'h00;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `UTF_OFF_EP_INDEX: reg_rdata_o <= {{(8-EPW){1'b0}}, ep_idx_r};
          `UTF_OFF_CONTROL:  reg_rdata_o <= ctl_all[ep_idx_r*8 +: 8];
          `UTF_OFF_FLAGS:    reg_rdata_o <= flg_all[ep_idx_r*8 +: 8];
          `UTF_OFF_STATUS:   reg_rdata_o <= stat_all[ep_idx_r*8 +: 8];
          default:           reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  assign se_data_o  = dq_all[se_ep_q_r*8 +: 8];
  assign se_ready_o = rdy_all[se_ep_i];

  ////////////////////////////////////////////////////////////////////////////
  // one fifo per endpoint
  genvar i;
  generate
    for (i = 0; i < NEP; i = i + 1) begin : g_ep
      reg  [AW:0]            wp_r;
      reg  [AW:0]            rp_r;
      reg  [AW:0]            rm_r;
      reg  [1:0]             armed_r;
      reg                    older_r;
      reg                    ovf_r;
      reg                    urf_r;
      reg                    urf_pend_r;
      reg  [1:0]             dec_pend_r;
      reg                    iso_r;
      reg                    auto_r;
      reg                    adv_r;
      reg                    rev_r;
      reg                    clr_r;
      reg  [`UTF_CNT_W-1:0]  fetched_r;
      reg                    ack_r;
      reg                    err_r;
      reg                    ack_pend_r;
      reg                    err_pend_r;
      reg  [1:0]             f1;
      reg  [1:0]             f2;
      reg  [1:0]             f3;
      wire [`UTF_CNT_W-1:0]  cur_cnt;
      wire [AW:0]            level = wp_r - rm_r;

      wire fw_sel  = (ep_idx_r == i);
      wire se_sel  = (se_ep_i == i);
      wire wr_data = reg_wr_i & fw_sel & (reg_addr_i == `UTF_OFF_DATA_PORT);
      wire wr_cnt  = reg_wr_i & fw_sel & (reg_addr_i == `UTF_OFF_BYTE_COUNT);
      wire wr_ctl  = reg_wr_i & fw_sel & (reg_addr_i == `UTF_OFF_CONTROL);
      wire wr_flg  = reg_wr_i & fw_sel & (reg_addr_i == `UTF_OFF_FLAGS);

      wire empty = (wp_r == rp_r);
      wire full  = (level == FULL_LEVEL);
      wire rd_set = rd_set_of(armed_r, older_r);
      wire wr_set = (armed_r == 2'b01);

      // data and count writes are discarded once both sets are armed
      wire data_ok = wr_data & ~full & (armed_r != 2'b11);
      wire data_ov = wr_data & ~data_ok;
      wire cnt_ok  = wr_cnt & (armed_r != 2'b11);
      wire cnt_ov  = wr_cnt & (armed_r == 2'b11);

      wire lock    = urf_r | urf_pend_r;
      wire fetch   = se_fetch_i & se_sel;
      wire under   = fetch & (empty | (armed_r == 2'b00) |
                              (fetched_r >= cur_cnt));
      wire good_rd = fetch & ~under & ~lock;

      wire done    = se_done_i & se_sel;
      wire ack     = done & se_ack_i & ~se_err_i;
      wire err     = done & se_err_i & ~se_ack_i;
      wire a_adv   = auto_r & (iso_r ? (ack | err) : ack);
      wire a_rev   = auto_r & ~iso_r & err;
      wire f_adv   = adv_r & ~rev_r & ~auto_r & ~clr_r;
      wire f_rev   = rev_r & ~adv_r & ~auto_r & ~clr_r;
      wire do_adv  = a_adv | f_adv;
      wire do_rev  = a_rev | f_rev;
      wire dec_now = f_adv | (a_adv & ~iso_r);
      wire dec_iso = a_adv & iso_r;

      // armed bits: deferred and immediate decrements first, then increment
      always @* begin
        f1 = dec_now ? armed_dec(armed_r, older_r) : armed_r;
        f2 = (sof_i && dec_pend_r != 2'b00) ? armed_dec(f1, older_r) : f1;
        f3 = (sof_i && dec_pend_r == 2'b10) ? armed_dec(f2, older_r) : f2;
        if (cnt_ok) begin
          f3 = (f3 == 2'b00) ? 2'b01 : 2'b11;
        end
      end

      always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          wp_r       <= {(AW+1){1'b0}};
          rp_r       <= {(AW+1){1'b0}};
          rm_r       <= {(AW+1){1'b0}};
          armed_r    <= 2'b00;
          older_r    <= 1'b0;
          ovf_r      <= 1'b0;
          urf_r      <= 1'b0;
          urf_pend_r <= 1'b0;
          dec_pend_r <= 2'b00;
          iso_r      <= 1'b0;
          auto_r     <= 1'b1;
          adv_r      <= 1'b0;
          rev_r      <= 1'b0;
          clr_r      <= 1'b0;
          fetched_r  <= {`UTF_CNT_W{1'b0}};
          ack_r      <= 1'b0;
          err_r      <= 1'b0;
          ack_pend_r <= 1'b0;
          err_pend_r <= 1'b0;
        end else if (clr_r) begin
          // clear request empties the fifo and drops pending armed and underrun updates
          wp_r       <= {(AW+1){1'b0}};
          rp_r       <= {(AW+1){1'b0}};
          rm_r       <= {(AW+1){1'b0}};
          armed_r    <= 2'b00;
          older_r    <= 1'b0;
          ovf_r      <= 1'b0;
          urf_r      <= 1'b0;
          urf_pend_r <= 1'b0;
          dec_pend_r <= 2'b00;
          adv_r      <= 1'b0;
          rev_r      <= 1'b0;
          clr_r      <= 1'b0;
          fetched_r  <= {`UTF_CNT_W{1'b0}};
        end else begin
          if (data_ok) begin
            wp_r <= wp_r + 1'b1;
          end
          if (do_rev) begin
            rp_r      <= rm_r;
            fetched_r <= {`UTF_CNT_W{1'b0}};
          end else if (do_adv) begin
            rm_r      <= rp_r;
            fetched_r <= {`UTF_CNT_W{1'b0}};
          end else if (good_rd) begin
            rp_r      <= rp_r + 1'b1;
            fetched_r <= fetched_r + 1'b1;
          end
          armed_r <= f3;
          if (cnt_ok && armed_r == 2'b01) begin
            older_r <= 1'b0;
          end else if (cnt_ok && armed_r == 2'b10) begin
            older_r <= 1'b1;
          end
          // usb-side updates wait for frame start in iso mode
          if (sof_i) begin
            dec_pend_r <= dec_iso ? 2'b01 : 2'b00;
          end else if (dec_iso && dec_pend_r != 2'b10) begin
            dec_pend_r <= dec_pend_r + 1'b1;
          end
          if (under && iso_r) begin
            urf_pend_r <= 1'b1;
          end else if (sof_i) begin
            urf_pend_r <= 1'b0;
          end
          // sticky flags: a new event wins over a firmware clear
          if ((under && !iso_r) || (sof_i && urf_pend_r)) begin
            urf_r <= 1'b1;
          end else if (wr_flg && !reg_wdata_i[`UTF_FLG_URF]) begin
            urf_r <= 1'b0;
          end
          if (data_ov || cnt_ov) begin
            ovf_r <= 1'b1;
          end else if (wr_flg && !reg_wdata_i[`UTF_FLG_OVF]) begin
            ovf_r <= 1'b0;
          end
          // transfer result, both bits written together
          if (done && !iso_r) begin
            ack_r <= ack;
            err_r <= err;
          end else if (sof_i && (ack_pend_r || err_pend_r)) begin
            ack_r      <= ack_pend_r;
            err_r      <= err_pend_r;
            ack_pend_r <= 1'b0;
            err_pend_r <= 1'b0;
          end
          if (done && iso_r) begin
            ack_pend_r <= ack;
            err_pend_r <= err;
          end
          if (wr_ctl) begin
            clr_r <= reg_wdata_i[`UTF_CTL_CLEAR];
            iso_r <= reg_wdata_i[`UTF_CTL_ISO];
            auto_r <= reg_wdata_i[`UTF_CTL_AUTO];
            adv_r <= reg_wdata_i[`UTF_CTL_ADVANCE];
            rev_r <= reg_wdata_i[`UTF_CTL_REWIND];
          end else begin
            if (f_adv) begin
              adv_r <= 1'b0;
            end
            if (f_rev) begin
              rev_r <= 1'b0;
            end
          end
        end
      end

      utf_byte_ram #(
        .DEPTH (DEPTH),
        .AW    (AW)
      ) u_ram (
        .ref_clk_i (ref_clk_i),
        .wr_en_i   (data_ok & ~clr_r),
        .wr_addr_i (wp_r[AW-1:0]),
        .wr_data_i (reg_wdata_i),
        .rd_en_i   (good_rd & ~clr_r),
        .rd_addr_i (rp_r[AW-1:0]),
        .rd_data_o (dq_all[i*8 +: 8])
      );

      utf_count_ring #(
        .CW (`UTF_CNT_W)
      ) u_cnt (
        .ref_clk_i  (ref_clk_i),
        .rstn_i     (rstn_i),
        .wr_en_i    (cnt_ok & ~clr_r),
        .wr_set_i   (wr_set),
        .wr_count_i (reg_wdata_i[`UTF_CNT_W-1:0]),
        .rd_set_i   (rd_set),
        .rd_count_o (cur_cnt)
      );

      assign cnt_all[i*`UTF_CNT_W +: `UTF_CNT_W] = cur_cnt;
      assign ctl_all[i*8 +: 8]  = {clr_r, 3'b000, iso_r, auto_r, adv_r, rev_r};
      assign flg_all[i*8 +: 8]  = {armed_r, 2'b00, empty, full, urf_r, ovf_r};
      assign stat_all[i*8 +: 8] = {6'b000000, err_r, ack_r};
      assign rdy_all[i] = (armed_r != 2'b00) & ~ovf_r & ~lock & ~clr_r;
    end
  endgenerate
endmodule // utf_tx_fifo

// ==== verification/utf_tx_fifo_monitor.sv ====
// concurrent checks on the transmit fifo register port and engine link
`timescale 1ns/100ps
`include "utf_defines.vh"
module utf_tx_fifo_monitor (
  input wire       ref_clk_i,
  input wire       rstn_i,
  input wire [7:0] reg_addr_i,
  input wire       reg_rd_i,
  input wire       reg_wr_i,
  input wire [7:0] reg_rdata_o,
  input wire       se_fetch_i,
  input wire [7:0] se_data_o,
  input wire       se_done_i,
  input wire       se_ack_i
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  reg  seen_r;
  wire rd_flg = reg_rd_i && (reg_addr_i == `UTF_OFF_FLAGS);
  wire rd_ctl = reg_rd_i && (reg_addr_i == `UTF_OFF_CONTROL);
  wire rd_st  = reg_rd_i && (reg_addr_i == `UTF_OFF_STATUS);
  wire rd_wo  = reg_rd_i && (reg_addr_i == `UTF_OFF_DATA_PORT ||
                             reg_addr_i == `UTF_OFF_BYTE_COUNT);
  // fetched byte is undefined until the first fetch
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      seen_r <= 1'b0;
    end else if (se_fetch_i) begin
      seen_r <= 1'b1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  chk_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not zero outside an answer");
  chk_unmapped_zero: assert property (reg_rd_i && reg_addr_i < 8'hf0 |-> ##1 !reg_rdata_o)
    else $error("unmapped read not zero");
  chk_wo_zero: assert property (rd_wo |=> reg_rdata_o == 8'h00)
    else $error("write-only read not zero");
  chk_flags_resv: assert property (rd_flg |=> reg_rdata_o[5:4] == 2'b00)
    else $error("flag reserved bits set");
  chk_empty_full: assert property (rd_flg |=> !(reg_rdata_o[3] && reg_rdata_o[2]))
    else $error("empty and full both set");
  chk_status_excl: assert property (rd_st |=> reg_rdata_o[1:0] != 2'b11)
    else $error("ack and error both set");
  chk_ctl_resv: assert property (rd_ctl |=> reg_rdata_o[6:4] == 3'h0)
    else $error("control reserved bits set");
  chk_data_hold: assert property (seen_r && !se_fetch_i |=> $stable(se_data_o))
    else $error("fetched byte changed without a fetch");
  cov_count_wr: cover property (reg_wr_i && reg_addr_i == `UTF_OFF_BYTE_COUNT);
  cov_fetch_b2b: cover property (se_fetch_i ##1 se_fetch_i);
  cov_done_ack: cover property (se_done_i && se_ack_i);
endmodule // utf_tx_fifo_monitor

bind utf_tx_fifo utf_tx_fifo_monitor u_mon (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o),
  .se_fetch_i(se_fetch_i), .se_data_o(se_data_o), .se_done_i(se_done_i),
  .se_ack_i(se_ack_i)
);

// ==== verification/utf_se_model.sv ====
// behavioural serial engine that reads one data set per command
`timescale 1ns/100ps
module utf_se_model (
  input  wire       ref_clk_i,
  input  wire       rstn_i,
  input  wire       go_i,
  input  wire       extra_i,
  input  wire [1:0] result_i,
  input  wire [3:0] gap_i,
  input  wire [4:0] se_count_i,
  input  wire [7:0] se_data_i,
  output reg        se_fetch_o,
  output reg        se_done_o,
  output reg        se_ack_o,
  output reg        se_err_o,
  output reg        busy_o
);
  reg [7:0] got [0:31];
  reg       cap_r;
  integer   n, k, j, g;
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {se_fetch_o, se_done_o, se_ack_o, se_err_o, busy_o, cap_r} <= 6'h00;
    end else begin
      {se_fetch_o, se_done_o, se_ack_o, se_err_o} <= 4'h0;
      cap_r <= se_fetch_o;
      if (cap_r) begin
        got[j] = se_data_i;
        j = j + 1;
      end
      if (go_i && !busy_o) begin
        busy_o <= 1'b1;
        n = se_count_i + extra_i; // length taken from the count store, plus one when extra_i is set
        k = 0;
        j = 0;
        g = 0;
      end else if (busy_o) begin
        if (g > 0) begin
          g = g - 1;
        end else if (k < n) begin
          se_fetch_o <= 1'b1;
          k = k + 1;
          g = gap_i;
        end else if (!se_fetch_o && !cap_r) begin
          // result levels travel with the done pulse
          {se_done_o, se_err_o, se_ack_o} <= {1'b1, result_i};
          busy_o <= 1'b0;
        end
      end
    end
  end
endmodule // utf_se_model

// ==== verification/tb_usb_endpoint_transmit_fifo.sv ====
// self-checking bench for the endpoint transmit fifo
`timescale 1ns/100ps
`include "utf_defines.vh"
module tb_usb_endpoint_transmit_fifo;
  localparam [7:0] IX = `UTF_OFF_EP_INDEX;
  localparam [7:0] DP = `UTF_OFF_DATA_PORT;
  localparam [7:0] CT = `UTF_OFF_CONTROL;
  localparam [7:0] FL = `UTF_OFF_FLAGS;
  localparam [7:0] BC = `UTF_OFF_BYTE_COUNT;
  localparam [7:0] ST = `UTF_OFF_STATUS;
  reg        ref_clk_i, rstn_i, reg_wr_i, reg_rd_i, sof_i, go_r, ext_r;
  reg  [7:0] reg_addr_i, reg_wdata_i, d;
  reg  [0:0] se_ep_i;
  reg  [1:0] res_r;
  reg  [3:0] gap_r;
  wire [7:0] reg_rdata_o, se_data_o;
  wire [4:0] se_count_o;
  wire       se_ready_o, se_fetch_i, se_done_i, se_ack_i, se_err_i, busy;
  integer    fail_count, checked, w;
  utf_tx_fifo dut (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .se_ep_i(se_ep_i), .se_fetch_i(se_fetch_i),
    .se_data_o(se_data_o), .se_count_o(se_count_o), .se_ready_o(se_ready_o),
    .se_done_i(se_done_i), .se_ack_i(se_ack_i), .se_err_i(se_err_i), .sof_i(sof_i));
  utf_se_model u_se (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .go_i(go_r), .extra_i(ext_r),
    .result_i(res_r), .gap_i(gap_r), .se_count_i(se_count_o), .se_data_i(se_data_o),
    .se_fetch_o(se_fetch_i), .se_done_o(se_done_i), .se_ack_o(se_ack_i),
    .se_err_o(se_err_i), .busy_o(busy));
  //////////////////////////////////////////////////////////////////////////////
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
    end
  endtask
  task chk(input [8*8-1:0] nm, input [7:0] e, input [7:0] s);
    begin
      checked = checked + 1;
      if (s !== e) begin
        fail_count = fail_count + 1;
        $display("mismatch %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task rchk(input [8*8-1:0] nm, input [7:0] a, input [7:0] e);
    begin
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      @(negedge ref_clk_i);
      d = reg_rdata_o & (nm == "underrun" ? 8'h02 : 8'hff);
      chk(nm, e, d);
    end
  endtask
  task rdy(input [7:0] e);
    begin
      @(negedge ref_clk_i);
      chk("ready", e, {7'h0, se_ready_o});
    end
  endtask
  task put(input [7:0] b, input [4:0] n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) wr(DP, b + i[7:0]); // sets kept to half the fifo
      wr(BC, {3'h0, n}); // count only after its bytes
    end
  endtask
  task gchk(input [7:0] b, input [4:0] n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) chk("byte", b + i[7:0], u_se.got[i]);
    end
  endtask
  task xfer(input [1:0] res, input ext, input [3:0] gp);
    integer t;
    begin
      @(posedge ref_clk_i);
      {res_r, ext_r, gap_r, go_r} <= {res, ext, gp, 1'b1};
      @(posedge ref_clk_i);
      go_r <= 1'b0;
      t = 0;
      @(negedge ref_clk_i);
      while (busy === 1'b1 && t < 100) begin
        @(negedge ref_clk_i);
        t = t + 1;
      end
      if (t == 100) fail_count = fail_count + 1;
      @(posedge ref_clk_i);
    end
  endtask
  task print_verdict;
    begin
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    #(40 * 4000);
    fail_count = fail_count + 1;
    print_verdict;
  end
  initial begin
    {rstn_i, reg_wr_i, reg_rd_i, sof_i, go_r, ext_r, res_r, gap_r} = 0;
    {reg_addr_i, reg_wdata_i, se_ep_i, fail_count, checked} = 0;
    repeat (4) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rchk("ctl", CT, 8'h04);
    rchk("flags", FL, 8'h08);
    rchk("unmapped", 8'h10, 8'h00);
    rchk("bcreg", BC, 8'h00);
    wr(IX, 8'h01);
    se_ep_i <= 1'b1;
    put(8'h11, 5'd3);
    wr(IX, 8'h00);
    rchk("flags", FL, 8'h08);
    wr(IX, 8'h01);
    rchk("flags", FL, 8'h40);
    chk("count", 8'h03, {3'h0, se_count_o});
    xfer(2'b01, 1'b0, 4'd2);
    gchk(8'h11, 5'd3);
    rchk("flags", FL, 8'h08);
    rchk("status", ST, 8'h01);
    put(8'h21, 5'd2);
    xfer(2'b10, 1'b0, 4'd0);
    rchk("flags", FL, 8'h40);
    rchk("status", ST, 8'h02);
    xfer(2'b01, 1'b0, 4'd0);
    gchk(8'h21, 5'd2);
    put(8'h31, 5'd1);
    put(8'h41, 5'd2);
    rchk("flags", FL, 8'hc0);
    wr(DP, 8'hee);
    rchk("flags", FL, 8'hc1);
    wr(BC, 8'h01);
    rchk("flags", FL, 8'hc1);
    rdy(8'h00);
    wr(FL, 8'h00);
    rdy(8'h01);
    xfer(2'b01, 1'b0, 4'd1);
    gchk(8'h31, 5'd1);
    rchk("flags", FL, 8'h80);
    xfer(2'b01, 1'b0, 4'd0);
    gchk(8'h41, 5'd2);
    put(8'h00, 5'd0);
    rchk("flags", FL, 8'h48);
    xfer(2'b01, 1'b0, 4'd0);
    rchk("flags", FL, 8'h08);
    put(8'h51, 5'd1);
    xfer(2'b00, 1'b0, 4'd0);
    rchk("flags", FL, 8'h48);
    rchk("status", ST, 8'h00);
    wr(CT, 8'h00);
    wr(CT, 8'h01);
    rchk("ctl", CT, 8'h00);
    rchk("flags", FL, 8'h40);
    xfer(2'b01, 1'b0, 4'd0);
    gchk(8'h51, 5'd1);
    rchk("flags", FL, 8'h48);
    wr(CT, 8'h06);
    rchk("ctl", CT, 8'h06);
    wr(CT, 8'h02);
    rchk("ctl", CT, 8'h00);
    rchk("flags", FL, 8'h08);
    wr(CT, 8'h04);
    put(8'h61, 5'd1);
    xfer(2'b01, 1'b1, 4'd0);
    rchk("underrun", FL, 8'h02);
    rdy(8'h00);
    wr(FL, 8'h00);
    for (w = 0; w < 17; w = w + 1) wr(DP, 8'h80);
    rchk("flags", FL, 8'h05);
    wr(CT, 8'h84);
    rchk("flags", FL, 8'h08);
    rchk("ctl", CT, 8'h04);
    wr(CT, 8'h0c);
    put(8'h71, 5'd1);
    rchk("flags", FL, 8'h40);
    xfer(2'b01, 1'b0, 4'd0);
    rchk("flags", FL, 8'h48);
    @(posedge ref_clk_i);
    sof_i <= 1'b1;
    @(posedge ref_clk_i);
    sof_i <= 1'b0;
    rchk("flags", FL, 8'h08);
    print_verdict;
  end
endmodule // tb_usb_endpoint_transmit_fifo
